// ### inc/lin_xcvr_map.vh
// register map, field positions and timing counts of the link transceiver control
// assumes a 200 MHz system clock; included by bare name
`ifndef LIN_XCVR_MAP_VH
`define LIN_XCVR_MAP_VH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_CHIP        12'h008
// ----------------------------------------
// fields
// ----------------------------------------
`define CTRL_MODE_LSB   0
`define CTRL_SLOPE_BIT  2
`define CTRL_WDOG_BIT   3
`define STAT_WAKE_BIT   0
`define STAT_FAIL_BIT   1
`define STAT_TXTO_BIT   2
`define STAT_CLAMP_BIT  3
// ----------------------------------------
// transceiver modes
// ----------------------------------------
`define XM_OFF          2'h0
`define XM_WAKE         2'h1
`define XM_RXONLY       2'h2
`define XM_NORMAL       2'h3
// ----------------------------------------
// chip modes
// ----------------------------------------
`define CM_NORMAL       3'h0
`define CM_STOP         3'h1
`define CM_SLEEP        3'h2
`define CM_RESTART      3'h3
`define CM_FAILSAFE     3'h4
`define CM_SWDEV        3'h5
// ----------------------------------------
// timing (times in us, counts in cycles, sized to the 24-bit counters)
// ----------------------------------------
`define CLK_MHZ         200
`define WAKE_FILT_US    30
`define WAKE_FILT_CYC   24'h001770
`define ENABLE_US       10
`define ENABLE_CYC      24'h0007D0
`define TX_TO_US        12000
`define TX_TO_CYC       24'h249F00
`define BUS_TO_US       12000
`define BUS_TO_CYC      24'h249F00
`endif

// ### rtl/lin_transceiver_mode_control.v
// link transceiver mode control: modes, enable delay, wake detect, time-outs, under-voltage, slope
// assumes synchronous pins, an APB master for the registers and chip mode supplied by the system
`timescale 1ns/10ps
`include "lin_xcvr_map.vh"
module lin_transceiver_mode_control #(
   parameter [23:0] WAKE_FILT_CYC = `WAKE_FILT_CYC,
   parameter [23:0] ENABLE_CYC    = `ENABLE_CYC,
   parameter [23:0] TX_TO_CYC     = `TX_TO_CYC,
   parameter [23:0] BUS_TO_CYC    = `BUS_TO_CYC
) (
   // clock and reset
   input  wire        clk_sys,
   input  wire        nrst,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // control port framing and chip state
   input  wire        cs_n,
   input  wire [2:0]  chip_mode,
   input  wire        wdog_enabled,
   input  wire        supply_uv,
   // microcontroller pins
   input  wire        link_tx_in,
   output reg         link_rx_pin,
   output reg         int_n,
   // bus side
   input  wire        bus_rx,
   output reg         bus_drive,
   output reg         low_slope,
   // system requests
   output reg         restart_req,
   output reg         wdog_enable_req
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function mode_allowed;
      input [1:0] m;
      input [2:0] c;
      begin
         case (m)
            `XM_OFF:    mode_allowed = 1'b1;
            `XM_NORMAL: mode_allowed = (c == `CM_NORMAL) || (c == `CM_SWDEV);
            `XM_RXONLY: mode_allowed = (c == `CM_NORMAL) || (c == `CM_STOP);
            `XM_WAKE:   mode_allowed = (c == `CM_STOP) || (c == `CM_SLEEP) ||
                                       (c == `CM_RESTART) || (c == `CM_NORMAL);
            default:    mode_allowed = 1'b0;
         endcase
      end
   endfunction

   function rearm_mode;
      input [2:0] c;
      begin
         rearm_mode = (c == `CM_STOP) || (c == `CM_SLEEP) || (c == `CM_FAILSAFE);
      end
   endfunction

   // wake here is reported by interrupt; the chip mode is left alone
   function irq_on_wake;
      input [2:0] c;
      begin
         irq_on_wake = (c == `CM_STOP) || (c == `CM_NORMAL);
      end
   endfunction

   // wake here asks the system for a restart and raises no interrupt
   function restart_on_wake;
      input [2:0] c;
      begin
         restart_on_wake = (c == `CM_SLEEP) || (c == `CM_FAILSAFE);
      end
   endfunction

   function rx_mode;
      input [1:0] m;
      begin
         rx_mode = (m == `XM_NORMAL) || (m == `XM_RXONLY);
      end
   endfunction

   // ----------------------------------------
   // registers and bus decode
   // ----------------------------------------
   reg  [1:0]  xmode;
   reg  [1:0]  pend_mode;
   reg         pend_mode_v;
   reg         pend_slope;
   reg         pend_slope_v;
   reg         wdog_on_bus_wake;
   reg         wake_flag;
   reg         txto_flag;
   reg         clamp_flag;
   reg         cs_n_q;
   reg  [2:0]  chip_q;
   reg         woken;
   reg         armed;
   reg         bus_q;
   reg  [23:0] dom_cnt;
   reg  [23:0] tx_cnt;
   reg  [23:0] bus_cnt;
   reg  [23:0] en_cnt;
   reg         en_done;
   reg         tx_block;
   reg         tx_to;
   reg         next_rx;
   reg  [31:0] next_rdata;
   wire        acc      = psel & penable;
   wire        wr       = acc & pwrite;
   wire        cs_rise  = cs_n & ~cs_n_q;
   wire        sel_ctrl = (paddr == `OFS_CTRL);
   wire        sel_stat = (paddr == `OFS_STATUS);
   wire        sel_chip = (paddr == `OFS_CHIP);
   wire        mapped   = sel_ctrl | sel_stat | sel_chip;
   wire        fail     = txto_flag | clamp_flag;
   wire        chip_chg = (chip_mode != chip_q);
   wire        xm_drive = (xmode == `XM_NORMAL);
   wire        xm_rx    = rx_mode(xmode);
   wire        txto_set = xm_drive && !link_tx_in && !tx_to && (tx_cnt >= TX_TO_CYC);
   wire        clamp_set = xm_rx && !bus_rx && (bus_cnt == BUS_TO_CYC);
   wire        wake_ev;
   wire        stat_clr;

   assign pready   = 1'b1;
   assign pslverr  = acc & ~mapped;
   assign stat_clr = wr & sel_stat;

   always @* begin
      next_rdata = 32'h0000_0000;
      if (sel_ctrl) begin
         next_rdata[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB] = xmode;
         next_rdata[`CTRL_SLOPE_BIT] = low_slope;
         next_rdata[`CTRL_WDOG_BIT]  = wdog_on_bus_wake;
      end else if (sel_stat) begin
         next_rdata[`STAT_WAKE_BIT]  = wake_flag;
         next_rdata[`STAT_FAIL_BIT]  = fail;
         next_rdata[`STAT_TXTO_BIT]  = txto_flag;
         next_rdata[`STAT_CLAMP_BIT] = clamp_flag;
      end else if (sel_chip) begin
         next_rdata[2:0] = chip_mode;
         next_rdata[4]   = woken;
         next_rdata[5]   = armed;
      end
   end

   // read word is taken in the setup cycle; a flag set during that cycle shows at the next read
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata <= next_rdata;
      end
   end

   // ----------------------------------------
   // mode and slope writes, held until chip-select rise
   // ----------------------------------------
   // a mode or slope write only pends until the serial frame ends; the watchdog bit lands at once
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pend_mode        <= `XM_OFF;
         pend_mode_v      <= 1'b0;
         pend_slope       <= 1'b0;
         pend_slope_v     <= 1'b0;
         wdog_on_bus_wake <= 1'b0;
         cs_n_q           <= 1'b1;
         chip_q           <= `CM_NORMAL;
      end else begin
         cs_n_q <= cs_n;
         chip_q <= chip_mode;
         if (wr && sel_ctrl) begin
            pend_mode        <= pwdata[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB];
            pend_mode_v      <= 1'b1;
            pend_slope       <= pwdata[`CTRL_SLOPE_BIT];
            pend_slope_v     <= 1'b1;
            wdog_on_bus_wake <= pwdata[`CTRL_WDOG_BIT];
         end else if (cs_rise) begin
            pend_mode_v  <= 1'b0;
            pend_slope_v <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // mode and slope, committed on chip-select rise
   // ----------------------------------------
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         xmode     <= `XM_OFF;
         low_slope <= 1'b0;
         armed     <= 1'b0;
      end else begin
         if (chip_mode == `CM_FAILSAFE) begin
            xmode <= `XM_WAKE;
            if (chip_chg) begin
               armed <= 1'b1;
            end
         end else if (cs_rise && pend_mode_v && mode_allowed(pend_mode, chip_mode)) begin
            if (pend_mode != xmode) begin
               armed <= (pend_mode == `XM_WAKE);
            end
            xmode <= pend_mode;
         end else if (chip_chg && rearm_mode(chip_mode) && (xmode == `XM_WAKE)) begin
            armed <= 1'b1;
         end
         if (cs_rise && pend_slope_v && (chip_mode == `CM_NORMAL)) begin
            low_slope <= pend_slope;
         end
      end
   end

   // ----------------------------------------
   // wake detection
   // ----------------------------------------
   // filter counts dominant length; the edge back to recessive qualifies the wake
   assign wake_ev = (xmode == `XM_WAKE) && armed && !woken && !supply_uv &&
                    bus_rx && !bus_q && (dom_cnt >= WAKE_FILT_CYC);

   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         bus_q           <= 1'b1;
         dom_cnt         <= 24'h000000;
         woken           <= 1'b0;
         wake_flag       <= 1'b0;
         int_n           <= 1'b1;
         restart_req     <= 1'b0;
         wdog_enable_req <= 1'b0;
      end else begin
         bus_q <= bus_rx;
         if (bus_rx) begin
            dom_cnt <= 24'h000000;
         end else if (dom_cnt != 24'hFFFFFF) begin
            dom_cnt <= dom_cnt + 24'h000001;
         end
         restart_req     <= 1'b0;
         wdog_enable_req <= 1'b0;
         if (wake_ev) begin
            woken     <= 1'b1;
            wake_flag <= 1'b1;
            if (irq_on_wake(chip_mode)) begin
               int_n <= 1'b0;
            end
            if (restart_on_wake(chip_mode)) begin
               restart_req <= 1'b1;
            end
            if ((chip_mode == `CM_STOP) && !wdog_enabled && wdog_on_bus_wake) begin
               wdog_enable_req <= 1'b1;
            end
         end else begin
            if (stat_clr && pwdata[`STAT_WAKE_BIT]) begin
               wake_flag <= 1'b0;
               int_n     <= 1'b1;
            end
            if (xmode != `XM_WAKE || (chip_chg && rearm_mode(chip_mode))) begin
               woken <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------
   // enable delay, transmit and bus time-outs
   // ----------------------------------------
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         en_cnt     <= 24'h000000;
         en_done    <= 1'b0;
         tx_block   <= 1'b1;
         tx_cnt     <= 24'h000000;
         tx_to      <= 1'b0;
         bus_cnt    <= 24'h000000;
         txto_flag  <= 1'b0;
         clamp_flag <= 1'b0;
      end else begin
         // enable delay restarts whenever driving becomes impossible
         if (!xm_drive || supply_uv || tx_to) begin
            en_cnt  <= 24'h000000;
            en_done <= 1'b0;
         end else if (!en_done) begin
            if (en_cnt >= ENABLE_CYC - 24'h000001) begin
               en_done <= 1'b1;
            end
            en_cnt <= en_cnt + 24'h000001;
         end
         // a low held from before the delay end is never sent
         if (!en_done) begin
            tx_block <= 1'b1;
         end else if (link_tx_in) begin
            tx_block <= 1'b0;
         end
         if (link_tx_in) begin
            tx_cnt <= 24'h000000;
            tx_to  <= 1'b0;
         end else if (xm_drive && !tx_to) begin
            if (tx_cnt >= TX_TO_CYC) begin
               tx_to <= 1'b1;
            end
            tx_cnt <= tx_cnt + 24'h000001;
         end
         if (bus_rx || !xm_rx) begin
            bus_cnt <= 24'h000000;
         end else if (bus_cnt <= BUS_TO_CYC) begin
            bus_cnt <= bus_cnt + 24'h000001;
         end
         if (txto_set) begin
            txto_flag <= 1'b1;
         end else if (stat_clr && pwdata[`STAT_TXTO_BIT]) begin
            txto_flag <= 1'b0;
         end
         if (clamp_set) begin
            clamp_flag <= 1'b1;
         end else if (stat_clr && pwdata[`STAT_CLAMP_BIT]) begin
            clamp_flag <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // pin outputs
   // ----------------------------------------
   // slope only shapes the driver edge rate; receive path ignores it
   always @* begin
      next_rx = 1'b1;
      if (woken) begin
         next_rx = 1'b0;
      end else if (xm_rx && !supply_uv) begin
         next_rx = bus_rx;
      end
   end

   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         link_rx_pin <= 1'b1;
         bus_drive   <= 1'b0;
      end else begin
         link_rx_pin <= next_rx;
         // controller is expected to hold the input high through the delay
         bus_drive <= xm_drive && !supply_uv && !tx_to && !tx_block && !link_tx_in;
      end
   end
endmodule

// ### tb/lin_xcvr_checker.sv
// port assertions for the link transceiver mode control
// assumes it is bound to the design top; chip mode codes come from the design header
`timescale 1ns/10ps
`include "lin_xcvr_map.vh"
module lin_xcvr_checker #(
   parameter [23:0] WAKE_FILT_CYC = 24'h14,
   parameter [23:0] ENABLE_CYC    = 24'h0A,
   parameter [23:0] TX_TO_CYC     = 24'h32,
   parameter [23:0] BUS_TO_CYC    = 24'h32
) (
   // clock and reset
   input wire       clk_sys,
   input wire       nrst,
   // watched inputs
   input wire       cs_n,
   input wire [2:0] chip_mode,
   input wire       wdog_enabled,
   input wire       supply_uv,
   input wire       link_tx_in,
   // watched outputs
   input wire       link_rx_pin,
   input wire       int_n,
   input wire       bus_drive,
   input wire       low_slope,
   input wire       restart_req,
   input wire       wdog_enable_req
);
   logic [23:0] drv_run;
   // ----------------------------------------
   // length of the current dominant drive
   // ----------------------------------------
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst)
         drv_run <= 24'h0;
      else
         drv_run <= bus_drive ? drv_run + 24'h1 : 24'h0;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   a_drive_follows_tx: assert property (bus_drive |-> !$past(link_tx_in))
      else $error("bus driven without a low transmit input");
   a_uv_silent: assert property (supply_uv |=> !bus_drive)
      else $error("bus driven during under-voltage");
   a_slope_commit: assert property ($changed(low_slope) |->
      $past(cs_n) && !$past(cs_n, 2) && $past(chip_mode) == `CM_NORMAL)
      else $error("slope changed outside a select rise in chip normal");
   a_tx_timeout: assert property (drv_run <= TX_TO_CYC + 24'h2)
      else $error("dominant drive outlived the transmit time-out");
   a_restart_cause: assert property (restart_req |-> int_n &&
      ($past(chip_mode) == `CM_SLEEP || $past(chip_mode) == `CM_FAILSAFE))
      else $error("restart request outside sleep or fail-safe");
   a_restart_pulse: assert property (restart_req |=> !restart_req)
      else $error("restart request longer than one cycle");
   a_wdog_cause: assert property (wdog_enable_req |->
      $past(chip_mode) == `CM_STOP && !$past(wdog_enabled))
      else $error("watchdog request without a stop-mode wake");
   a_wake_signal: assert property ($fell(int_n) |->
      ($past(chip_mode) == `CM_STOP || $past(chip_mode) == `CM_NORMAL) ##1 !link_rx_pin)
      else $error("interrupt without receive low in stop or normal");
endmodule

// ### tb/lin_bus_partner.sv
// controller pin and single-wire bus model
// assumes the bench steers tx_dom, early and remote_dom right after rising edges
`timescale 1ns/10ps
module lin_bus_partner #(
   parameter ENABLE_CYC = 10
) (
   // clock and framing
   input  wire clk_sys,
   input  wire cs_n,
   // levels
   input  wire bus_drive,
   input  wire tx_dom,
   input  wire early,
   input  wire remote_dom,
   output wire bus_rx,
   output wire link_tx_in
);
   int   cnt  = 0;
   logic cs_q = 1'b1;
   // unless early is set, controller keeps its pin recessive until the enable delay is surely over
   always @(posedge clk_sys) begin
      cs_q <= cs_n;
      cnt <= (cs_n && !cs_q) ? 0 : (cnt < ENABLE_CYC + 4 ? cnt + 1 : cnt);
   end
   assign link_tx_in = !(tx_dom && (early || cnt > ENABLE_CYC + 3));
   // pull-up: a released bus reads recessive
   assign bus_rx = !(bus_drive || remote_dom);
endmodule

// ### tb/tb_lin_transceiver_mode_control.sv
// self-checking bench of the link transceiver mode control
// assumes the design header on the include path; the master waits for pready at a rising edge
`timescale 1ns/10ps
`include "lin_xcvr_map.vh"
module tb_lin_transceiver_mode_control;
   localparam [23:0] WF = 24'h14, EN = 24'h0A, TO = 24'h32;
   localparam RX = 0, IRQ = 1, DRV = 2, SLP = 3, RST = 4, WDQ = 5;
   typedef struct {string n; logic [31:0] v; logic [31:0] m; int i;} note_t;
   note_t       q[$];
   note_t       e;
   logic [31:0] got, pwdata = 0;
   logic [11:0] paddr = 0;
   logic [2:0]  chip_mode = `CM_NORMAL;
   logic        clk_sys = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, cs_n = 1;
   logic        wdog_enabled = 0, supply_uv = 0, tx_dom = 0, early = 0, remote_dom = 0;
   logic        probe = 0, saw_rst = 0, saw_wd = 0;
   int          fail_count = 0, check_count = 0, seed = 30, n;
   wire [31:0]  prdata;
   wire         pready, pslverr, link_tx_in, link_rx_pin, int_n, bus_rx, bus_drive;
   wire         low_slope, restart_req, wdog_enable_req;
   wire [5:0]   pins = {saw_wd, saw_rst, low_slope, bus_drive, int_n, link_rx_pin};
   lin_transceiver_mode_control #(.WAKE_FILT_CYC(WF), .ENABLE_CYC(EN), .TX_TO_CYC(TO), .BUS_TO_CYC(TO)) dut (
      .clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cs_n(cs_n),
      .chip_mode(chip_mode), .wdog_enabled(wdog_enabled), .supply_uv(supply_uv), .link_tx_in(link_tx_in),
      .link_rx_pin(link_rx_pin), .int_n(int_n), .bus_rx(bus_rx), .bus_drive(bus_drive),
      .low_slope(low_slope), .restart_req(restart_req), .wdog_enable_req(wdog_enable_req));
   lin_bus_partner #(.ENABLE_CYC(EN)) far (.clk_sys(clk_sys), .cs_n(cs_n), .bus_drive(bus_drive),
      .tx_dom(tx_dom), .early(early), .remote_dom(remote_dom), .bus_rx(bus_rx), .link_tx_in(link_tx_in));
   // ----------------------------------------
   // clock, pulse catchers and result monitor
   // ----------------------------------------
   initial forever #2.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (restart_req) saw_rst <= 1;
      if (wdog_enable_req) saw_wd <= 1;
      if (probe || (psel && penable && pready && !pwrite)) begin
         e = q.pop_front();
         got = probe ? {31'h0, pins[e.i]} : (e.i < 0 ? {31'h0, pslverr} : prdata & e.m);
         check_count++;
         if (got !== e.v) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", e.n, e.v, got);
         end
      end
   end
   // ----------------------------------------
   // drivers
   // ----------------------------------------
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1;
      @(posedge clk_sys);
      while (!pready) @(posedge clk_sys);
      psel <= 0; penable <= 0;
      @(posedge clk_sys);
   endtask
   task rd(input string s, input logic [11:0] a, input logic [31:0] v, input logic [31:0] m);
      q.push_back('{s, v, m, 0});
      apb(0, a, 32'h0);
   endtask
   task chk(input string s, input int i, input logic v);
      q.push_back('{s, {31'h0, v}, 32'h1, i});
      probe <= 1;
      @(posedge clk_sys);
      probe <= 0;
      @(posedge clk_sys);
   endtask
   // mode and slope only land on the select rise
   task cmd(input logic [31:0] d);
      cs_n <= 0;
      apb(1, `OFS_CTRL, d);
      cs_n <= 1;
      repeat (3) @(posedge clk_sys);
   endtask
   task pulse(input int k);
      remote_dom <= 1;
      repeat (k) @(posedge clk_sys);
      remote_dom <= 0;
      repeat (4) @(posedge clk_sys);
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #100000;
      fail_count++;
      complete_run;
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge clk_sys);
      nrst <= 1;
      @(posedge clk_sys);
      rd("ctrl", `OFS_CTRL, 32'h0, 32'hF);
      rd("status", `OFS_STATUS, 32'h0, 32'hF);
      rd("chip", `OFS_CHIP, {29'h0, `CM_NORMAL}, 32'h7);
      q.push_back('{"slverr", 32'h1, 32'h1, -2});
      apb(0, 12'h00C, 32'h0);
      early <= 1; tx_dom <= 1;
      pulse(WF + 10);
      chk("drive off", DRV, 0);
      chk("int off", IRQ, 1);
      chip_mode <= `CM_STOP;
      cmd(32'h3);
      repeat (EN + 5) @(posedge clk_sys);
      chk("normal in stop", DRV, 0);
      tx_dom <= 0; chip_mode <= `CM_NORMAL;
      $display("off and gating done");
      cmd(32'h3);
      tx_dom <= 1;
      repeat (EN + 5) @(posedge clk_sys);
      chk("early low", DRV, 0);
      tx_dom <= 0;
      @(posedge clk_sys);
      tx_dom <= 1;
      repeat (3) @(posedge clk_sys);
      chk("dominant", DRV, 1);
      chk("rx dominant", RX, 0);
      tx_dom <= 0; early <= 0;
      repeat (3) @(posedge clk_sys);
      chk("rx recessive", RX, 1);
      $display("enable done");
      tx_dom <= 1;
      repeat (TO + 10) @(posedge clk_sys);
      chk("tx timeout", DRV, 0);
      rd("fail flags", `OFS_STATUS, 32'h6, 32'h6);
      tx_dom <= 0;
      @(posedge clk_sys);
      tx_dom <= 1;
      repeat (EN + 5) @(posedge clk_sys);
      chk("delay after timeout", DRV, 0);
      tx_dom <= 0;
      @(posedge clk_sys);
      tx_dom <= 1;
      repeat (3) @(posedge clk_sys);
      chk("drive back", DRV, 1);
      tx_dom <= 0;
      apb(1, `OFS_STATUS, 32'hF);
      n = TO + 5 + ($random(seed) & 7);
      pulse(n);
      rd("clamp", `OFS_STATUS, 32'hA, 32'hA);
      apb(1, `OFS_STATUS, 32'hF);
      $display("time-outs done");
      supply_uv <= 1; tx_dom <= 1; remote_dom <= 1;
      repeat (3) @(posedge clk_sys);
      chk("uv drive", DRV, 0);
      chk("uv rx", RX, 1);
      remote_dom <= 0; tx_dom <= 0; supply_uv <= 0;
      @(posedge clk_sys);
      tx_dom <= 1;
      repeat (3) @(posedge clk_sys);
      chk("uv delay", DRV, 0);
      tx_dom <= 0;
      repeat (EN + 5) @(posedge clk_sys);
      tx_dom <= 1;
      repeat (3) @(posedge clk_sys);
      chk("uv back", DRV, 1);
      tx_dom <= 0;
      rd("uv mode", `OFS_CTRL, 32'h3, 32'h3);
      cmd(32'h7);
      chk("slope set", SLP, 1);
      chip_mode <= `CM_STOP;
      cmd(32'h3);
      chk("slope in stop", SLP, 1);
      chip_mode <= `CM_NORMAL;
      cmd(32'h3);
      chk("slope back", SLP, 0);
      $display("uv and slope done");
      chip_mode <= `CM_STOP;
      cmd(32'h2);
      repeat (EN + 5) @(posedge clk_sys);
      tx_dom <= 1; remote_dom <= 1;
      repeat (3) @(posedge clk_sys);
      chk("rxonly drive", DRV, 0);
      chk("rxonly rx", RX, 0);
      tx_dom <= 0; remote_dom <= 0;
      cmd(32'h9);
      pulse(WF - 5);
      chk("short wake", IRQ, 1);
      n = WF + 5 + ($random(seed) & 7);
      pulse(n);
      chk("wake int", IRQ, 0);
      chk("wake rx", RX, 0);
      chk("wdog req", WDQ, 1);
      chk("no restart", RST, 0);
      rd("wake mode", `OFS_CTRL, 32'h1, 32'h3);
      rd("chip kept", `OFS_CHIP, {29'h0, `CM_STOP}, 32'h7);
      apb(1, `OFS_STATUS, 32'h1);
      chk("int cleared", IRQ, 1);
      cmd(32'h1);
      pulse(WF + 5);
      chk("no rearm", IRQ, 1);
      cmd(32'h0);
      chk("rx released", RX, 1);
      cmd(32'h1);
      pulse(WF + 5);
      chk("rearmed", IRQ, 0);
      apb(1, `OFS_STATUS, 32'h1);
      $display("wake in stop done");
      chip_mode <= `CM_SLEEP;
      repeat (3) @(posedge clk_sys);
      chk("sleep rx", RX, 1);
      pulse(WF + 5);
      chk("restart", RST, 1);
      chk("sleep int", IRQ, 1);
      cmd(32'h0);
      chip_mode <= `CM_FAILSAFE;
      repeat (3) @(posedge clk_sys);
      rd("failsafe mode", `OFS_CTRL, 32'h1, 32'h3);
      $display("wake in sleep done");
      complete_run;
   end
endmodule
bind lin_transceiver_mode_control lin_xcvr_checker #(.WAKE_FILT_CYC(WAKE_FILT_CYC), .ENABLE_CYC(ENABLE_CYC),
   .TX_TO_CYC(TX_TO_CYC), .BUS_TO_CYC(BUS_TO_CYC)) chk_i (.clk_sys(clk_sys), .nrst(nrst), .cs_n(cs_n),
   .chip_mode(chip_mode), .wdog_enabled(wdog_enabled), .supply_uv(supply_uv), .link_tx_in(link_tx_in),
   .link_rx_pin(link_rx_pin), .int_n(int_n), .bus_drive(bus_drive), .low_slope(low_slope),
   .restart_req(restart_req), .wdog_enable_req(wdog_enable_req));
